//--- nvs_array_model.sv
/* Behavioural model of the flash and EEPROM arrays.
   Assumes one request at a time; slow_i stretches every erase and write. */
`timescale 1ns/1ps
module nvs_array_model (
  // Clock, reset and pace
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  // Request and answers
  input wire nvs_pkg::nvs_req_t req_i,
  output logic [13:0] rdata_o,
  output logic done_o,
  // Observation
  output logic [13:0] mem_o [32],
  output logic [13:0] ee_data_o,
  output int wr_cnt_o,
  output int er_cnt_o,
  output logic bad_o
);
  import nvs_pkg::*;
  // ----------------------------------------------------------------------
  // Array behaviour
  // ----------------------------------------------------------------------
  logic [13:0] hold;
  logic [4:0] cnt;
  logic [10:0] row;
  logic ee;
  nvs_req_t last;
  assign ee = req_i.addr[15:12] == 4'hF;
  // Outside the read cycle the data lines toggle, so a sample one cycle late never matches.
  assign rdata_o = (req_i.valid && req_i.op == NVS_OP_READ) ? req_i.addr[13:0] ^ 14'h2AAA : ~hold;
  always_ff @(posedge clk_i) begin
    hold <= rdata_o;
    done_o <= rst_n_i && cnt == 5'h01;
    cnt <= (cnt != 5'h00) ? cnt - 5'h01 : cnt;
    if (!rst_n_i) begin
      cnt <= 5'h00;
      hold <= 14'h0000;
      wr_cnt_o <= 0;
      er_cnt_o <= 0;
      bad_o <= 1'b0;
    end else if (req_i.valid && req_i.op != NVS_OP_READ) begin
      cnt <= slow_i ? 5'h14 : 5'h02;
      last <= req_i;
      er_cnt_o <= er_cnt_o + (req_i.op == NVS_OP_ERASE_ROW);
      if (req_i.op == NVS_OP_ERASE_WORD && !ee) bad_o <= 1'b1;
      if (req_i.op == NVS_OP_WRITE_WORD && ee) begin
        ee_data_o <= req_i.data;
        if (last.op != NVS_OP_ERASE_WORD || last.addr != req_i.addr) bad_o <= 1'b1;
      end
      if (req_i.op == NVS_OP_WRITE_WORD && !ee) begin
        mem_o[req_i.addr[4:0]] <= req_i.data;
        wr_cnt_o <= wr_cnt_o + 1;
        if (req_i.addr[4:0] == 5'h00) row <= req_i.addr[15:5];
        if (req_i.addr[4:0] != wr_cnt_o[4:0] ||
            (req_i.addr[4:0] != 5'h00 && req_i.addr[15:5] != row)) bad_o <= 1'b1;
      end
    end
  end
endmodule

//--- nvs_pkg.sv
/*
  Package for the self-programming sequencer: unlock keys, address windows,
  latch layout, reset values and the request carried to the memory arrays.
  Assumes the arrays answer each erase or write request with a done pulse.
*/
package nvs_pkg;

  // ----------------------------------------------------------------------
  // Unlock keys and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] NVS_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVS_KEY_SECOND = 8'hAA;
  localparam logic [13:0] NVS_LATCH_BLANK = 14'h3FFF;
  localparam logic [13:0] NVS_DATA_RESET = 14'h0000;
  localparam logic [7:0] NVS_ADDR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Latch and row layout
  // ----------------------------------------------------------------------
  localparam int NVS_LATCH_COUNT = 32;
  localparam int NVS_LATCH_BITS = 5;
  localparam logic [4:0] NVS_LATCH_LAST = 5'h1F;

  // ----------------------------------------------------------------------
  // Configuration space windows
  // ----------------------------------------------------------------------
  localparam logic [15:0] NVS_UID_LO = 16'h8000;
  localparam logic [15:0] NVS_UID_HI = 16'h8003;
  localparam logic [15:0] NVS_ID_LO = 16'h8005;
  localparam logic [15:0] NVS_CFG_HI = 16'h800B;
  localparam logic [15:0] NVS_EE_LO = 16'hF000;
  localparam logic [15:0] NVS_EE_HI = 16'hF0FF;

  // ----------------------------------------------------------------------
  // Unlock progress and array request
  // ----------------------------------------------------------------------
  localparam logic [1:0] NVS_UNLOCK_IDLE = 2'h0;
  localparam logic [1:0] NVS_UNLOCK_HALF = 2'h1;
  localparam logic [1:0] NVS_UNLOCK_ARMED = 2'h2;

  typedef enum logic [1:0] {
    NVS_OP_READ,
    NVS_OP_ERASE_ROW,
    NVS_OP_ERASE_WORD,
    NVS_OP_WRITE_WORD
  } nvs_op_t;

  typedef struct packed {
    logic valid;
    logic cfg_space;
    nvs_op_t op;
    logic [15:0] addr;
    logic [13:0] data;
  } nvs_req_t;

endpackage

//--- nvs_sequencer.sv
/*
  Self-programming sequencer: unlock tracking, EEPROM word write with implicit
  erase, row erase, write-latch loading, row programming and register reads.
  Assumes the arrays return read data combinationally, in the same cycle as the read request, and
  pulse arr_done_i once per erase or write request.
*/
`timescale 1ns/1ps

// Functional notes
// - Keys 55h then AAh, then go
// - EEPROM write erases word, then writes
// - EEPROM runs unstalled; done clears go, flags
// - Clearing go during EEPROM write ignored
// - Flash erase is whole row only
// - Flash write never erases first
// - Protected erase clears go, skipped
// - Erase stalls CPU, then sets done
// - Erase blanks latches; enable untouched
// - Row from high/low bits; latch index
// - Programming limited to one row
// - Latches blank when an operation sets done
// - Latch-only mode loads one latch
// - Otherwise load last latch, program row
// - Broken unlock starts nothing
// - Read returns data next cycle, self-clears
// - Code protection blocks all accesses
// - Unmapped config read clears data
// - Flash erase and row write stall CPU until done
module nvs_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control bits
  input wire logic config_space_select_i,
  input wire logic program_enable_i,
  input wire logic latch_only_load_i,
  input wire logic row_erase_select_i,
  input wire logic nvm_done_irq_enable_i,
  input wire logic code_protect_i,
  input wire logic write_protect_i,
  // Software strobes
  input wire logic key_wr_i,
  input wire logic [7:0] key_data_i,
  input wire logic other_access_i,
  input wire logic prog_go_set_i,
  input wire logic prog_go_clr_i,
  input wire logic read_go_set_i,
  input wire logic done_clr_i,
  // Address and data registers
  input wire logic [7:0] target_addr_high_i,
  input wire logic [7:0] target_addr_low_i,
  input wire logic word_data_high_we_i,
  input wire logic word_data_low_we_i,
  input wire logic [7:0] byte_wdata_i,
  // Array answers
  input wire logic [13:0] arr_rdata_i,
  input wire logic arr_done_i,
  // Status
  output logic prog_go_o,
  output logic read_go_o,
  output logic nvm_done_flag_o,
  output logic irq_o,
  output logic cpu_stall_o,
  output logic [13:0] word_data_o,
  // Array request
  output nvs_pkg::nvs_req_t nvm_req_o
);
  import nvs_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_ERASE, ST_EE_ERASE, ST_EE_WRITE, ST_LATCH, ST_PROG, ST_FINISH
  } nvs_state_t;

  nvs_state_t state_reg, state_next;
  logic [1:0] unlock_reg, unlock_next;
  logic wait_reg, wait_next;
  logic [4:0] idx_reg, idx_next;
  logic go_reg, go_next;
  logic rd_reg, rd_next;
  logic done_reg, done_next;
  logic irq_reg, irq_next;
  logic stall_reg, stall_next;
  logic [13:0] data_reg, data_next;
  nvs_req_t req_reg, req_next;
  logic [13:0] latch_mem [NVS_LATCH_COUNT];
  logic latch_we, latch_clear;

  logic [15:0] addr;
  logic [9:0] row;
  logic [4:0] lidx;
  logic in_uid, in_ee, readable, armed;

  assign addr = {target_addr_high_i, target_addr_low_i};
  assign row = {target_addr_high_i[6:0], target_addr_low_i[7:5]};
  assign lidx = target_addr_low_i[4:0];
  assign in_uid = (addr >= NVS_UID_LO) && (addr <= NVS_UID_HI);
  assign in_ee = (addr >= NVS_EE_LO) && (addr <= NVS_EE_HI);
  assign readable = in_uid || in_ee || ((addr >= NVS_ID_LO) && (addr <= NVS_CFG_HI));
  assign armed = (unlock_reg == NVS_UNLOCK_ARMED);

  // ----------------------------------------------------------------------
  // Unlock tracking
  // ----------------------------------------------------------------------
  always_comb begin
    unlock_next = unlock_reg;
    if (key_wr_i) begin
      if (key_data_i == NVS_KEY_FIRST) begin
        unlock_next = NVS_UNLOCK_HALF;
      end else if (key_data_i == NVS_KEY_SECOND && unlock_reg == NVS_UNLOCK_HALF) begin
        unlock_next = NVS_UNLOCK_ARMED;
      end else begin
        unlock_next = NVS_UNLOCK_IDLE;
      end
    end else if (other_access_i || prog_go_set_i) begin
      unlock_next = NVS_UNLOCK_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    idx_next = idx_reg;
    go_next = go_reg;
    rd_next = 1'b0;
    done_next = done_reg;
    data_next = data_reg;
    req_next = '0;
    latch_we = 1'b0;
    latch_clear = 1'b0;
    if (done_clr_i) begin
      done_next = 1'b0;
    end
    if (word_data_low_we_i) begin
      data_next[7:0] = byte_wdata_i;
    end
    if (word_data_high_we_i) begin
      data_next[13:8] = byte_wdata_i[5:0];
    end
    unique case (state_reg)
      ST_IDLE: begin
        wait_next = 1'b0;
        idx_next = '0;
        if (read_go_set_i && !code_protect_i) begin
          if (config_space_select_i && !readable) begin
            data_next = NVS_DATA_RESET;
          end else begin
            req_next = '{1'b1, config_space_select_i, NVS_OP_READ, addr, 14'h0000};
            rd_next = 1'b1;
            state_next = ST_READ;
          end
        end else if (prog_go_set_i && armed && program_enable_i && !code_protect_i) begin
          // Any failed unlock, missing enable, code protection or write-protected flash erase leaves go low.
          if (config_space_select_i && in_ee) begin
            go_next = 1'b1;
            state_next = ST_EE_ERASE;
          end else if (config_space_select_i && !in_uid) begin
            go_next = 1'b0;
          end else if (row_erase_select_i) begin
            if (!config_space_select_i && write_protect_i) begin
              go_next = 1'b0;
            end else begin
              go_next = 1'b1;
              state_next = ST_ERASE;
            end
          end else begin
            go_next = 1'b1;
            latch_we = 1'b1;
            state_next = latch_only_load_i ? ST_LATCH : ST_PROG;
          end
        end
      end
      ST_READ: begin
        data_next = arr_rdata_i;
        state_next = ST_IDLE;
      end
      ST_ERASE: begin
        if (!wait_reg) begin
          // A whole row is the only erase unit for flash.
          req_next = '{1'b1, config_space_select_i, NVS_OP_ERASE_ROW,
                       {target_addr_high_i, row[2:0], 5'h00}, 14'h0000};
          wait_next = 1'b1;
        end else if (arr_done_i) begin
          state_next = ST_FINISH;
        end
      end
      ST_EE_ERASE: begin
        if (!wait_reg) begin
          req_next = '{1'b1, 1'b1, NVS_OP_ERASE_WORD, addr, 14'h0000};
          wait_next = 1'b1;
        end else if (arr_done_i) begin
          wait_next = 1'b0;
          state_next = ST_EE_WRITE;
        end
      end
      ST_EE_WRITE: begin
        if (!wait_reg) begin
          req_next = '{1'b1, 1'b1, NVS_OP_WRITE_WORD, addr, data_reg};
          wait_next = 1'b1;
        end else if (arr_done_i) begin
          state_next = ST_FINISH;
        end
      end
      ST_LATCH: begin
        go_next = 1'b0;
        state_next = ST_IDLE;
      end
      ST_PROG: begin
        if (!wait_reg) begin
          // Plain word writes, no erase, confined to the addressed row.
          req_next = '{1'b1, config_space_select_i, NVS_OP_WRITE_WORD,
                       {target_addr_high_i, row[2:0], idx_reg}, latch_mem[idx_reg]};
          wait_next = 1'b1;
        end else if (arr_done_i) begin
          wait_next = 1'b0;
          if (idx_reg == NVS_LATCH_LAST) begin
            state_next = ST_FINISH;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      ST_FINISH: begin
        latch_clear = 1'b1;
        go_next = 1'b0;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
    // Software cannot abort a running operation; prog_go_clr_i only matters in
    // the EEPROM states, where the CPU still runs, and is dropped there.
    // Program enable is an input here, so no operation can alter it.
    irq_next = done_next && nvm_done_irq_enable_i;
    // Stall is registered, so it follows the state that is being entered.
    stall_next = (state_next == ST_READ) || (state_next == ST_ERASE) ||
                 (state_next == ST_LATCH) || (state_next == ST_PROG) ||
                 (state_next == ST_FINISH && state_reg != ST_EE_WRITE);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      unlock_reg <= NVS_UNLOCK_IDLE;
      wait_reg <= 1'b0;
      idx_reg <= '0;
      go_reg <= 1'b0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      stall_reg <= 1'b0;
      data_reg <= NVS_DATA_RESET;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      unlock_reg <= unlock_next;
      wait_reg <= wait_next;
      idx_reg <= idx_next;
      go_reg <= go_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
      stall_reg <= stall_next;
      data_reg <= data_next;
      req_reg <= req_next;
    end
  end

  // ----------------------------------------------------------------------
  // Write latches
  // ----------------------------------------------------------------------
  // Erase never loads data into the latches; they are only blanked at the end.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NVS_LATCH_COUNT; i++) begin
      if (!rst_n_i || latch_clear) begin
        latch_mem[i] <= NVS_LATCH_BLANK;
      end else if (latch_we && lidx == i[NVS_LATCH_BITS-1:0]) begin
        latch_mem[i] <= data_reg;
      end
    end
  end

  assign prog_go_o = go_reg;
  assign read_go_o = rd_reg;
  assign nvm_done_flag_o = done_reg;
  assign irq_o = irq_reg;
  assign cpu_stall_o = stall_reg;
  assign word_data_o = data_reg;
  assign nvm_req_o = req_reg;

endmodule

//--- nvs_sequencer_chk.sv
/* Port checker for the self-programming sequencer.
   Assumes a bind onto every sequencer instance and one clock domain. */
`timescale 1ns/1ps
module nvs_sequencer_chk (
  // Control inputs
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic config_space_select_i,
  input wire logic program_enable_i,
  input wire logic latch_only_load_i,
  input wire logic row_erase_select_i,
  input wire logic nvm_done_irq_enable_i,
  input wire logic code_protect_i,
  input wire logic write_protect_i,
  input wire logic prog_go_set_i,
  input wire logic [7:0] target_addr_high_i,
  input wire logic [7:0] target_addr_low_i,
  // Observed outputs
  input wire logic prog_go_o,
  input wire logic read_go_o,
  input wire logic nvm_done_flag_o,
  input wire logic irq_o,
  input wire logic cpu_stall_o,
  input wire nvs_pkg::nvs_req_t nvm_req_o
);
  import nvs_pkg::*;
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic v;
  assign v = nvm_req_o.valid;
  property p_go;
    $rose(prog_go_o) |-> $past(prog_go_set_i) && $past(program_enable_i); endproperty
  a_go: assert property (p_go) else $error("go rose without a request");
  property p_prot;
    code_protect_i && !prog_go_o && !read_go_o |=> !prog_go_o && !read_go_o; endproperty
  a_prot: assert property (p_prot) else $error("access under protection");
  property p_wp;
    write_protect_i && row_erase_select_i && !config_space_select_i && !latch_only_load_i
      && prog_go_set_i && !prog_go_o |=> !prog_go_o; endproperty
  a_wp: assert property (p_wp) else $error("protected erase started");
  // A latch load holds go for one cycle only, so longer runs must end with done.
  property p_fin;
    $fell(prog_go_o) && $past(prog_go_o, 2) |-> nvm_done_flag_o; endproperty
  a_fin: assert property (p_fin) else $error("end without done");
  property p_irq;
    irq_o == (nvm_done_flag_o && $past(nvm_done_irq_enable_i)); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_er;
    v && nvm_req_o.op == NVS_OP_ERASE_ROW |-> cpu_stall_o && nvm_req_o.addr[4:0] == 5'h00 &&
      nvm_req_o.addr[15:5] == {target_addr_high_i, target_addr_low_i[7:5]};
  endproperty
  a_er: assert property (p_er) else $error("bad row erase");
  property p_ee;
    v && nvm_req_o.op == NVS_OP_ERASE_WORD |-> nvm_req_o.cfg_space && !cpu_stall_o; endproperty
  a_ee: assert property (p_ee) else $error("bad word erase");
  property p_rd;
    $rose(read_go_o) |-> cpu_stall_o ##1 !read_go_o; endproperty
  a_rd: assert property (p_rd) else $error("read go not one cycle");
  c_er: cover property (v && nvm_req_o.op == NVS_OP_ERASE_ROW);
  c_ee: cover property (v && nvm_req_o.op == NVS_OP_WRITE_WORD && nvm_req_o.cfg_space);
  c_rd: cover property ($rose(read_go_o));
endmodule
bind nvs_sequencer nvs_sequencer_chk i_chk (.clk_i, .rst_n_i, .config_space_select_i,
  .program_enable_i, .latch_only_load_i, .row_erase_select_i, .nvm_done_irq_enable_i,
  .code_protect_i, .write_protect_i, .prog_go_set_i, .target_addr_high_i, .target_addr_low_i,
  .prog_go_o, .read_go_o,
  .nvm_done_flag_o, .irq_o, .cpu_stall_o, .nvm_req_o);

//--- tb.sv
/* Self-checking bench for the sequencer with the array model behind it.
   Assumes the package, the sequencer, the model and the checker compile first. */
`timescale 1ns/1ps
module tb;
  import nvs_pkg::*;
  typedef struct packed {logic c; logic [15:0] a; logic [13:0] e;} nvs_row_t;
  logic clk_i, rst_n_i, cfg, pe, llo, res, ie, cp, wp, kw, oa, gs, gc, rs, dc, dh, dl, slow;
  logic go, rgo, dn, irq, st, done, bad, seen;
  logic [7:0] key, ah, al, bw;
  logic [13:0] rd, wd, ee;
  logic [13:0] mem [32];
  nvs_req_t req;
  int wr, er, n, bad_count, cmp_count;
  nvs_row_t rows [5] = '{{1'b0, 16'h0123, 14'h2B89}, {1'b1, 16'h8004, 14'h0000},
    {1'b1, 16'h8002, 14'h2AA8}, {1'b1, 16'hF100, 14'h0000}, {1'b1, 16'hF0FF, 14'h1A55}};
  nvs_sequencer i_dut (.clk_i, .rst_n_i, .config_space_select_i(cfg), .program_enable_i(pe),
    .latch_only_load_i(llo), .row_erase_select_i(res), .nvm_done_irq_enable_i(ie),
    .code_protect_i(cp), .write_protect_i(wp), .key_wr_i(kw), .key_data_i(key),
    .other_access_i(oa), .prog_go_set_i(gs), .prog_go_clr_i(gc), .read_go_set_i(rs),
    .done_clr_i(dc), .target_addr_high_i(ah), .target_addr_low_i(al),
    .word_data_high_we_i(dh), .word_data_low_we_i(dl), .byte_wdata_i(bw),
    .arr_rdata_i(rd), .arr_done_i(done), .prog_go_o(go), .read_go_o(rgo),
    .nvm_done_flag_o(dn), .irq_o(irq), .cpu_stall_o(st), .word_data_o(wd), .nvm_req_o(req));
  nvs_array_model i_arr (.clk_i, .rst_n_i, .slow_i(slow), .req_i(req), .rdata_o(rd),
    .done_o(done), .mem_o(mem), .ee_data_o(ee), .wr_cnt_o(wr), .er_cnt_o(er), .bad_o(bad));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic setd(input logic [13:0] d);
    bw = d[7:0];
    dl = 1;
    tick();
    dl = 0;
    bw = {2'b00, d[13:8]};
    dh = 1;
    tick();
    dh = 0;
    chk(wd, d);
  endtask
  // The go clear is pulsed in any run that keeps go high for four cycles, since it must never cut one short.
  task automatic run(input logic [7:0] k1, input logic [7:0] k2, input logic mid);
    kw = 1;
    key = k1;
    tick();
    if (mid) begin
      kw = 0;
      oa = 1;
      tick();
      oa = 0;
      kw = 1;
    end
    key = k2;
    tick();
    kw = 0;
    gs = 1;
    tick();
    gs = 0;
    seen = 0;
    // A slow row program needs about 740 cycles, so the limit sits well above it.
    for (n = 0; go === 1'b1 && n < 1000; n++) begin
      seen |= st;
      gc = (n == 3);
      tick();
    end
    gc = 0;
    chk(go, 0);
  endtask
  task automatic clr();
    dc = 1;
    tick();
    dc = 0;
    chk(dn, 0);
  endtask
  task automatic conclude();
    $display("counts: %0d compares, %0d wrong", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  initial begin
    {rst_n_i, cfg, pe, llo, res, ie, cp, wp, kw, oa, gs, gc, rs, dc, dh, dl, slow} = '0;
    {key, ah, al, bw} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) tick();
    rst_n_i = 1;
    chk({1'b0, go, rgo, dn, irq, st, wd}, 0);
    pe = 1;
    foreach (rows[i]) begin
      cfg = rows[i].c;
      {ah, al} = rows[i].a;
      rs = 1;
      tick();
      rs = 0;
      if (rows[i].e != 14'h0000) chk({st, rgo}, 2'h3);
      else chk({st, rgo}, 2'h0);
      tick();
      chk(wd, rows[i].e);
    end
    $display("test reads ended");
    {cfg, llo, ah, al} = {2'b01, 16'h01E4};
    setd(14'h2222);
    run(8'h55, 8'hAA, 1); chk(n != 0, 0);
    run(8'hAA, 8'h55, 0); chk(n != 0, 0);
    run(8'h55, 8'h3C, 0); chk(n != 0, 0);
    pe = 0;
    run(8'h55, 8'hAA, 0);
    chk(n != 0, 0);
    pe = 1;
    for (int i = 0; i < 3; i++) begin
      al = 8'hE0 + 8'(i);
      setd(14'h0100 + 14'(i));
      run(8'h55, 8'hAA, 0);
      chk({seen, wr[7:0]}, 9'h100);
    end
    llo = 0;
    al = 8'hE3;
    setd(14'h0ABC);
    run(8'h55, 8'hAA, 0);
    chk({bad, dn, seen, wr[7:0]}, {3'b011, 8'd32});
    foreach (mem[i]) chk(mem[i], i < 3 ? 14'h0100 + i : i == 3 ? 14'h0ABC : 14'h3FFF);
    clr();
    slow = 1;
    al = 8'hE5;
    setd(14'h1234);
    run(8'h55, 8'hAA, 0);
    chk(mem[0], 14'h3FFF);
    chk({mem[5], wr[5:0]}, {14'h1234, 6'd0});
    clr();
    $display("test program ended");
    {res, ie, wp} = 3'b111;
    run(8'h55, 8'hAA, 0);
    chk({n != 0, er[3:0]}, 0);
    wp = 0;
    run(8'h55, 8'hAA, 0);
    chk({seen, dn, irq, er[3:0]}, {3'b111, 4'd1});
    clr();
    {res, ie, cfg, ah, al} = {3'b001, 16'hF010};
    setd(14'h00AB);
    run(8'h55, 8'hAA, 0);
    chk({seen, dn, irq, bad, ee}, {4'b0100, 14'h00AB});
    chk(wr[7:0], 8'd64);
    clr();
    $display("test erase and eeprom ended");
    {cp, cfg} = 2'b10;
    run(8'h55, 8'hAA, 0);
    rs = 1;
    tick();
    rs = 0;
    chk({st, rgo}, 2'h0);
    tick();
    chk({n != 0, rgo, wd}, {2'b00, 14'h00AB});
    $display("test protection ended");
    conclude();
  end
endmodule
